// ===== bcs_pkg.sv
/*
  Constants and types for the battery charge sequencer.
  Assumes a 100 MHz system clock and a nominal 800 Hz charge-timing tick.
*/
`default_nettype none
package bcs_pkg;

  localparam int CLK_HZ = 100_000_000;
  localparam int OSC_HZ = 800;

  // Times in milliseconds, counts in oscillator ticks
  localparam int CYCLE_MS         = 20480;
  localparam int BREAK_MS         = 2560;
  localparam int BRK_DELAY_MS     = 40;
  localparam int BRK_PULSE_MS     = 10;
  localparam int D2_HOLD_MS       = 300000;
  localparam int PREFORM_WARN_MS  = 600000;
  localparam int TOPOFF_MS        = 1200000;
  localparam int CHARGE_PULSE_MS  = 5120;

  localparam int CYCLE_TICKS      = CYCLE_MS * OSC_HZ / 1000;
  localparam int BREAK_TICKS      = BREAK_MS * OSC_HZ / 1000;
  localparam int BRK_DELAY_TICKS  = BRK_DELAY_MS * OSC_HZ / 1000;
  localparam int BRK_PULSE_TICKS  = BRK_PULSE_MS * OSC_HZ / 1000;
  localparam int D2_HOLD_TICKS    = D2_HOLD_MS * OSC_HZ / 1000;
  localparam int PREFORM_WARN_TICKS = PREFORM_WARN_MS * OSC_HZ / 1000;
  localparam int TOPOFF_TICKS     = TOPOFF_MS * OSC_HZ / 1000;
  localparam int CHARGE_PULSE_TICKS = CHARGE_PULSE_MS * OSC_HZ / 1000;
  localparam int BREAK_START      = CYCLE_TICKS - BREAK_TICKS;
  localparam int BRK_PULSE_START  = BREAK_START + BRK_DELAY_TICKS;
  localparam int BRK_PULSE_END    = BRK_PULSE_START + BRK_PULSE_TICKS;

  // Trickle period is 1310.72 s, i.e. 64 measurement cycles
  localparam int TRICKLE_CYC_W    = 6;
  localparam int CYC_W            = 14;
  localparam int TIM_W            = 20;
  localparam int BLINK_BIT        = 9;

  // Converter: 10-bit code, 6.5 mV per step
  localparam int CODE_W           = 10;
  localparam int LSB_UV           = 6500;
  localparam int VREF_MV          = 1600;
  localparam int DROP_MV          = 12;
  localparam int OVERLOAD_MV      = 4000;
  localparam logic [CODE_W-1:0] VREF_CODE     = CODE_W'(VREF_MV * 1000 / LSB_UV);
  localparam logic [CODE_W-1:0] DROP_CODE     = CODE_W'((DROP_MV * 1000 + LSB_UV - 1) / LSB_UV);
  localparam logic [CODE_W-1:0] OVERLOAD_CODE = CODE_W'(OVERLOAD_MV * 1000 / LSB_UV);
  localparam int D2_LIMIT_LSB     = 2;
  localparam logic [1:0] DROP_CYCLES = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_PREFORM = 3'b001,
    ST_FAST    = 3'b010,
    ST_TOPOFF  = 3'b011,
    ST_TRICKLE = 3'b100
  } bcs_state_t;

endpackage
`default_nettype wire

// ===== bcs_sequencer.sv
/*
  Charge-state sequencer: preformation, fast charge with -dV and d2V/dt2
  termination, pulsed top-off, trickle, break pulse and status LEDs.
  Assumes battCode is a settled converter code, valid whenever sampled,
  and packPresent is a clean level synchronous to clk.
  The power stage sets the actual rates; this block only gates them.
  Temperature window and test mode are handled outside, if at all.
*/
`timescale 1ns/100ps
`default_nettype none
module bcs_sequencer #(
  parameter int OSC_DIV = bcs_pkg::CLK_HZ / bcs_pkg::OSC_HZ
) (
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire logic                        packPresent,
  input  wire logic [bcs_pkg::CODE_W-1:0]  battCode,
  output var  logic                        fastCurrentOn,
  output var  logic                        preformCurrentOn,
  output var  logic                        chargeBreakPulse,
  output var  logic                        redStatus,
  output var  logic                        greenStatus
);

  typedef struct packed {
    bcs_pkg::bcs_state_t                 st;
    logic [16:0]                         divCnt;
    logic [bcs_pkg::CYC_W-1:0]           cycCnt;
    logic [bcs_pkg::TIM_W-1:0]           insTim;
    logic [bcs_pkg::TIM_W-1:0]           phTim;
    logic [bcs_pkg::TRICKLE_CYC_W-1:0]   trkCnt;
    logic [bcs_pkg::CODE_W-1:0]          actual;
    logic [bcs_pkg::CODE_W-1:0]          prev;
    logic signed [bcs_pkg::CODE_W:0]     prevDelta;
    logic [1:0]                          histValid;
    logic [1:0]                          dropCnt;
    logic                                pres;
    logic                                fastOn;
    logic                                preOn;
    logic                                brk;
    logic                                red;
    logic                                green;
  } bcs_regs_t;

  bcs_regs_t s_q;
  bcs_regs_t s_d;

  logic                              tick;
  logic                              lastCyc;
  logic                              drop;
  logic                              d2Hit;
  logic                              inBreak;
  logic                              pulseWin;
  logic signed [bcs_pkg::CODE_W:0]   delta;
  logic signed [bcs_pkg::CODE_W+1:0] accel;

  always_comb begin
    s_d      = s_q;
    // One cycle counter drives breaks, charge pulses and blinking alike
    tick     = (s_q.divCnt == 17'(OSC_DIV - 1));
    lastCyc  = (s_q.cycCnt == bcs_pkg::CYC_W'(bcs_pkg::CYCLE_TICKS - 1));
    delta    = $signed({1'b0, battCode}) - $signed({1'b0, s_q.prev});
    accel    = {delta[bcs_pkg::CODE_W], delta} -
               {s_q.prevDelta[bcs_pkg::CODE_W], s_q.prevDelta};
    // Margin goes on the new code, so a small stored value cannot underflow
    // drop detect
    drop     = s_q.histValid[0] &&
               ({1'b0, battCode} + {1'b0, bcs_pkg::DROP_CODE} <= {1'b0, s_q.actual});
    // Signed compare: a falling slope must never read as a large rise
    // second derivative held off
    d2Hit    = s_q.histValid[1] &&
               (s_q.insTim >= bcs_pkg::TIM_W'(bcs_pkg::D2_HOLD_TICKS)) &&
               (accel > $signed(12'(bcs_pkg::D2_LIMIT_LSB)));
    s_d.divCnt = tick ? 17'h0_0000 : s_q.divCnt + 17'h0_0001;
    s_d.pres   = packPresent;

    if (!packPresent) begin
      // Without a pack only the divider keeps counting
      s_d        = '0;
      s_d.divCnt = tick ? 17'h0_0000 : s_q.divCnt + 17'h0_0001;
    end else if (!s_q.pres) begin
      s_d      = '0;
      s_d.pres = 1'b1;
      // Decided on the code seen at the insertion edge; no settling wait
      // fast only above reference
      s_d.st   = (battCode > bcs_pkg::VREF_CODE) ? bcs_pkg::ST_FAST : bcs_pkg::ST_PREFORM;
    end else if (tick) begin
      s_d.cycCnt = lastCyc ? '0 : s_q.cycCnt + 1'b1;
      // Timers saturate so a long trickle cannot wrap into an early window
      if (s_q.insTim != '1) begin
        s_d.insTim = s_q.insTim + 1'b1;
      end
      if (s_q.phTim != '1) begin
        s_d.phTim = s_q.phTim + 1'b1;
      end
      if (lastCyc) begin
        s_d.trkCnt = s_q.trkCnt + 1'b1;
      end
      unique case (s_q.st)
        bcs_pkg::ST_PREFORM: begin
          if (lastCyc && battCode > bcs_pkg::VREF_CODE) begin
            s_d.st = bcs_pkg::ST_FAST;
          end
        end
        bcs_pkg::ST_FAST: begin
          if (lastCyc) begin
            s_d.prev      = battCode;
            s_d.prevDelta = delta;
            s_d.histValid = {s_q.histValid[0], 1'b1};
            s_d.dropCnt   = drop ? s_q.dropCnt + 2'h1 : 2'h0;
            // The stored value only climbs, so a slow sag still counts as a drop
            if (!drop && (!s_q.histValid[0] || battCode > s_q.actual)) begin
              s_d.actual = battCode;
            end
            // Overload wins: a saturated reading makes both terminations moot
            if (battCode >= bcs_pkg::OVERLOAD_CODE) begin
              s_d.st     = bcs_pkg::ST_TRICKLE;
              s_d.trkCnt = '0;
            end else if (d2Hit || (drop && s_q.dropCnt == bcs_pkg::DROP_CYCLES - 2'h1)) begin
              s_d.st    = bcs_pkg::ST_TOPOFF;
              s_d.phTim = '0;
            end
          end
        end
        bcs_pkg::ST_TOPOFF: begin
          if (s_q.phTim == bcs_pkg::TIM_W'(bcs_pkg::TOPOFF_TICKS - 1)) begin
            // The measurement cycle keeps running so breaks stay evenly spaced;
            // trkCnt reaches zero at the next cycle start, where the first
            // trickle pulse then begins.
            s_d.st     = bcs_pkg::ST_TRICKLE;
            s_d.trkCnt = lastCyc ? '0 : '1;
          end
        end
        bcs_pkg::ST_TRICKLE: begin
        end
        // Not held while a pack is seated: insertion always picks a phase
        bcs_pkg::ST_IDLE: begin
        end
        default: begin
          s_d.st = bcs_pkg::ST_IDLE;
        end
      endcase
    end

    // Outputs are computed from next state so that they leave flip-flops
    inBreak  = s_d.cycCnt >= bcs_pkg::CYC_W'(bcs_pkg::BREAK_START);
    pulseWin = s_d.cycCnt < bcs_pkg::CYC_W'(bcs_pkg::CHARGE_PULSE_TICKS);
    // Limitation: no temperature window, current follows the phase alone
    // Top-off and trickle pulse the fast stage; the duty cycle sets the rate
    // current off in break
    // trickle pulse once per 64 cycles
    s_d.fastOn = ((s_d.st == bcs_pkg::ST_FAST) && !inBreak) ||
                 ((s_d.st == bcs_pkg::ST_TOPOFF) && pulseWin) ||
                 ((s_d.st == bcs_pkg::ST_TRICKLE) && pulseWin && (s_d.trkCnt == '0));
    s_d.preOn  = (s_d.st == bcs_pkg::ST_PREFORM) && !inBreak;
    s_d.brk    = (s_d.st != bcs_pkg::ST_IDLE) &&
                 (s_d.cycCnt >= bcs_pkg::CYC_W'(bcs_pkg::BRK_PULSE_START)) &&
                 (s_d.cycCnt <  bcs_pkg::CYC_W'(bcs_pkg::BRK_PULSE_END));
    // Green stays steady once fast charge has ended
    // green blink early in preformation
    // red blink after the warning time
    s_d.red    = (s_d.st == bcs_pkg::ST_PREFORM) &&
                 (s_d.insTim >= bcs_pkg::TIM_W'(bcs_pkg::PREFORM_WARN_TICKS)) &&
                 s_d.cycCnt[bcs_pkg::BLINK_BIT];
    s_d.green  = (((s_d.st == bcs_pkg::ST_PREFORM) &&
                   (s_d.insTim < bcs_pkg::TIM_W'(bcs_pkg::PREFORM_WARN_TICKS))) ||
                  (s_d.st == bcs_pkg::ST_FAST)) ? s_d.cycCnt[bcs_pkg::BLINK_BIT] :
                 ((s_d.st == bcs_pkg::ST_TOPOFF) || (s_d.st == bcs_pkg::ST_TRICKLE));
  end

  // Synchronous reset only; removing the pack clears state as well
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign fastCurrentOn    = s_q.fastOn;
  assign preformCurrentOn = s_q.preOn;
  assign chargeBreakPulse = s_q.brk;
  assign redStatus        = s_q.red;
  assign greenStatus      = s_q.green;

endmodule
`default_nettype wire

// ===== bcs_seq_properties.sv
/* Port properties of the charge sequencer, bound to it below.
   Assumes one tick every OSC_DIV clk cycles, as in the design. */
`timescale 1ns/100ps
`default_nettype none
module bcs_seq_properties #(
  parameter int OSC_DIV = 1
) (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       packPresent,
  input wire logic [9:0] battCode,
  input wire logic       fastCurrentOn,
  input wire logic       preformCurrentOn,
  input wire logic       chargeBreakPulse,
  input wire logic       redStatus,
  input wire logic       greenStatus
);
  logic [31:0] pulseCnt_q;
  logic [31:0] gapCnt_q;
  logic        gapOk_q;
  wire logic   allOff;
  assign allOff = !(fastCurrentOn | preformCurrentOn | chargeBreakPulse | redStatus | greenStatus);
  // Gap is only judged between two pulses of one uninterrupted insertion
  always_ff @(posedge clk) begin
    pulseCnt_q <= chargeBreakPulse ? pulseCnt_q + 32'h1 : 32'h0;
    gapCnt_q   <= ($rose(chargeBreakPulse) | !packPresent) ? 32'h1 : gapCnt_q + 32'h1;
    gapOk_q    <= packPresent & !sys_rst & (gapOk_q | $rose(chargeBreakPulse));
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence insertS;
    $rose(packPresent);
  endsequence
  sequence goneS;
    !packPresent ##1 !packPresent;
  endsequence
  reset_quiet_a: assert property ($fell(sys_rst) |-> allOff)
    else $error("output active after reset");
  removal_clear_a: assert property (goneS |=> allOff)
    else $error("output active without pack");
  insert_fast_a: assert property (insertS ##0 battCode > bcs_pkg::VREF_CODE
    |-> ##2 fastCurrentOn && !preformCurrentOn) else $error("no fast charge at insertion");
  insert_preform_a: assert property (insertS ##0 battCode <= bcs_pkg::VREF_CODE
    |-> ##2 preformCurrentOn && !fastCurrentOn) else $error("no preformation at insertion");
  single_rate_a: assert property (!(fastCurrentOn && preformCurrentOn))
    else $error("both charge rates on");
  break_off_a: assert property (chargeBreakPulse |-> !fastCurrentOn && !preformCurrentOn)
    else $error("current on during break pulse");
  pulse_len_a: assert property ($fell(chargeBreakPulse) && packPresent
    |-> pulseCnt_q == bcs_pkg::BRK_PULSE_TICKS * OSC_DIV)
    else $error("break pulse length wrong");
  cycle_len_a: assert property ($rose(chargeBreakPulse) && gapOk_q
    |-> gapCnt_q == bcs_pkg::CYCLE_TICKS * OSC_DIV)
    else $error("measurement cycle length wrong");
  led_excl_a: assert property (!(redStatus && greenStatus))
    else $error("red and green together");
endmodule
bind bcs_sequencer bcs_seq_properties #(.OSC_DIV(OSC_DIV)) props (.clk(clk), .sys_rst(sys_rst),
  .packPresent(packPresent), .battCode(battCode), .fastCurrentOn(fastCurrentOn),
  .preformCurrentOn(preformCurrentOn), .chargeBreakPulse(chargeBreakPulse),
  .redStatus(redStatus), .greenStatus(greenStatus));
`default_nettype wire

// ===== bcs_pack_model.sv
/* Battery pack model: presence contact and converter code.
   Assumes the bench moves seated and cellCode off the sampling edge. */
`timescale 1ns/100ps
`default_nettype none
module bcs_pack_model (
  input  wire logic       seated,
  input  wire logic [9:0] cellCode,
  output var  logic       packPresent,
  output var  logic [9:0] battCode
);
  // Empty holder: sense line pulled up beyond the converter range
  always_comb begin
    packPresent = seated;
    battCode    = seated ? cellCode : 10'h3FF;
  end
endmodule
`default_nettype wire

// ===== bcs_sequencer_tb_top.sv
/* Self-checking bench for the charge sequencer with a pack model.
   Assumes OSC_DIV of 1, so one tick is one clk cycle. */
`timescale 1ns/100ps
`default_nettype none
module bcs_sequencer_tb_top;
  typedef struct packed {logic [9:0] code; logic [4:0] outs;} bcs_row_t;
  localparam int CYC = bcs_pkg::CYCLE_TICKS;
  bcs_row_t  rows [4] = '{'{10'h0F7, 5'h10}, '{10'h0F6, 5'h08}, '{10'h001, 5'h08},
                          '{10'h258, 5'h10}};
  logic       clk = 1'b0;
  logic       sysRst = 1'b1;
  logic       seated = 1'b0;
  logic [9:0] level = 10'h000;
  int         cyc = 0;
  int         t0 = 0;
  int         errTotal = 0;
  int         checked = 0;
  wire logic       packPresent;
  wire logic [9:0] battCode;
  wire logic [4:0] outs;
  bcs_pack_model pack (.seated(seated), .cellCode(level), .packPresent(packPresent),
    .battCode(battCode));
  bcs_sequencer #(.OSC_DIV(1)) dut (.clk(clk), .sys_rst(sysRst), .packPresent(packPresent),
    .battCode(battCode), .fastCurrentOn(outs[4]), .preformCurrentOn(outs[3]),
    .chargeBreakPulse(outs[2]), .redStatus(outs[1]), .greenStatus(outs[0]));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic stopTest();
    $display("comparisons %0d mismatches %0d", checked, errTotal);
    if (errTotal == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Bound a hang by the expected run length
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc >= 115000) begin
      errTotal = errTotal + 1;
      stopTest();
    end
  end
  task automatic check(input string what, input logic [4:0] seen, input logic [4:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      errTotal = errTotal + 1;
      $display("[ERR] %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic waitTo(input int p);
    while (cyc < t0 + p) @(negedge clk);
  endtask
  task automatic insertPack(input logic [9:0] code);
    @(negedge clk);
    seated = 1'b0;
    repeat (3) @(negedge clk);
    level = code;
    seated = 1'b1;
    t0 = cyc + 1;
  endtask
  initial begin
    repeat (6) @(negedge clk);
    sysRst = 1'b0;
    foreach (rows[i]) begin
      insertPack(rows[i].code);
      waitTo(10);
      check("insert outputs", outs, rows[i].outs);
    end
    insertPack(10'h0C8);
    waitTo(600);
    check("preform blink", outs, 5'h09);
    waitTo(14350);
    check("break start", outs, 5'h00);
    waitTo(14372);
    check("break pulse", outs, 5'h04);
    waitTo(14390);
    check("pulse end", outs, 5'h00);
    level = 10'h12C;
    waitTo(CYC + 20);
    check("promoted", outs, 5'h10);
    level = 10'h267;
    waitTo(2 * CYC + 4200);
    check("overload trickle", outs, 5'h01);
    insertPack(10'h12C);
    waitTo(CYC + 1000);
    // Exactly two codes below the seed: smallest drop that counts
    level = 10'h12A;
    waitTo(3 * CYC + 5000);
    check("two drops", outs, 5'h11);
    waitTo(4 * CYC + 100);
    check("topoff on", outs, 5'h11);
    waitTo(4 * CYC + 4200);
    check("topoff off", outs, 5'h01);
    sysRst = 1'b1;
    repeat (2) @(negedge clk);
    check("mid reset", outs, 5'h00);
    sysRst = 1'b0;
    seated = 1'b0;
    repeat (3) @(negedge clk);
    check("removed", outs, 5'h00);
    stopTest();
  end
endmodule
`default_nettype wire
